// File: core/byte_load_reg.sv
`timescale 1ns/1ps
module byte_load_reg
   import transfer_ops_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       load,
   input  wire logic [7:0] din,
   output logic      [7:0] q
);

   byte_state_t state_ff;
   byte_state_t nxt_state;

   // ***************************************
   // next value
   // ***************************************
   always_comb begin
      nxt_state = state_ff;
      if (load) begin
         nxt_state.value = din;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_ff <= '{value: TIMER_RESET};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign q = state_ff.value;

endmodule

// File: core/timer_reload_transfer_ops.sv
`timescale 1ns/1ps
module timer_reload_transfer_ops
   import transfer_ops_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire instr_req_t req,
   input  wire operand_t   opnd,
   input  wire logic [3:0] port_out_bits,
   output logic      [7:0] first_timer_count,
   output logic      [7:0] first_timer_low_reload,
   output logic      [7:0] first_timer_high_reload,
   output logic      [7:0] second_timer_count,
   output logic      [7:0] second_timer_low_reload,
   output logic      [7:0] second_timer_high_reload,
   output logic            skip_next,
   output logic            exec_done
);

   ctrl_state_t ctrl_ff;
   ctrl_state_t nxt_ctrl;

   logic [7:0] ab_word;
   logic       in_idle;
   logic       dec_t1_low;
   logic       dec_t1_high;
   logic       dec_copy_t1;
   logic       dec_t2_low;
   logic       dec_t2_high;
   logic       dec_skip_w1;
   logic       dec_skip_w2;
   logic       ptr_ok;
   logic       port_bit;
   logic       t1_count_load;
   logic [7:0] t1_count_din;

   // ***************************************
   // decode
   // ***************************************
   assign ab_word     = {opnd.breg, opnd.acc};
   assign in_idle     = (ctrl_ff.state == ST_IDLE);
   assign dec_t1_low  = req.valid && in_idle && (req.code == OP_LOAD_T1_LOW);
   assign dec_t1_high = req.valid && in_idle && (req.code == OP_LOAD_T1_HIGH);
   assign dec_copy_t1 = req.valid && in_idle && (req.code == OP_COPY_LOW_T1);
   assign dec_t2_low  = req.valid && in_idle && (req.code == OP_LOAD_T2_LOW);
   assign dec_t2_high = req.valid && in_idle && (req.code == OP_LOAD_T2_HIGH);
   assign dec_skip_w1 = req.valid && in_idle && (req.code == OP_SKIP_PORT_W1);
   assign dec_skip_w2 = req.valid && !in_idle && (req.code == OP_SKIP_PORT_W2);

   // out-of-range pointer is left to software; here it simply never skips
   assign ptr_ok   = (opnd.ptr_y <= PTR_LIMIT);
   assign port_bit = port_out_bits[opnd.ptr_y[1:0]];

   // counter strobe includes the low reload strobe so both change on one edge
   assign t1_count_load = dec_t1_low || dec_copy_t1;
   assign t1_count_din  = dec_t1_low ? ab_word : first_timer_low_reload;

   // ***************************************
   // destination registers
   // ***************************************
   byte_load_reg u_t1_count (
      .mclk (mclk),
      .rst  (rst),
      .load (t1_count_load),
      .din  (t1_count_din),
      .q    (first_timer_count)
   );

   byte_load_reg u_t1_low (
      .mclk (mclk),
      .rst  (rst),
      .load (dec_t1_low),
      .din  (ab_word),
      .q    (first_timer_low_reload)
   );

   byte_load_reg u_t1_high (
      .mclk (mclk),
      .rst  (rst),
      .load (dec_t1_high),
      .din  (ab_word),
      .q    (first_timer_high_reload)
   );

   byte_load_reg u_t2_count (
      .mclk (mclk),
      .rst  (rst),
      .load (dec_t2_low),
      .din  (ab_word),
      .q    (second_timer_count)
   );

   byte_load_reg u_t2_low (
      .mclk (mclk),
      .rst  (rst),
      .load (dec_t2_low),
      .din  (ab_word),
      .q    (second_timer_low_reload)
   );

   byte_load_reg u_t2_high (
      .mclk (mclk),
      .rst  (rst),
      .load (dec_t2_high),
      .din  (ab_word),
      .q    (second_timer_high_reload)
   );

   // ***************************************
   // sequencing of the two-word skip test
   // ***************************************
   always_comb begin
      nxt_ctrl           = ctrl_ff;
      nxt_ctrl.skip_next = 1'b0;
      nxt_ctrl.done      = 1'b0;
      unique case (ctrl_ff.state)
         ST_IDLE: begin
            if (dec_skip_w1) begin
               nxt_ctrl.state = ST_SKIP;
            end else if (dec_t1_low || dec_t1_high || dec_copy_t1 || dec_t2_low || dec_t2_high) begin
               nxt_ctrl.done = 1'b1;
            end
         end
         ST_SKIP: begin
            // a stray word in place of the second word drops the test
            if (req.valid) begin
               nxt_ctrl.state = ST_IDLE;
               if (dec_skip_w2) begin
                  nxt_ctrl.done      = 1'b1;
                  nxt_ctrl.skip_next = ptr_ok && !port_bit;
               end
            end
         end
         default: begin
            nxt_ctrl.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= '{state: ST_IDLE, skip_next: 1'b0, done: 1'b0};
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   assign skip_next = ctrl_ff.skip_next;
   assign exec_done = ctrl_ff.done;

   // ***************************************
   // checks
   // ***************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence skip_first_s;
      dec_skip_w1;
   endsequence

   sequence skip_second_zero_s;
      req.valid && (req.code == OP_SKIP_PORT_W2) && ptr_ok && !port_bit;
   endsequence

   sequence skip_second_one_s;
      req.valid && (req.code == OP_SKIP_PORT_W2) && ptr_ok && port_bit;
   endsequence

   skip_on_zero_a: assert property (
      skip_first_s ##1 skip_second_zero_s |=> skip_next && exec_done)
      else $error("port skip missed on zero bit");

   run_on_one_a: assert property (
      skip_first_s ##1 skip_second_one_s |=> !skip_next ##1 !skip_next)
      else $error("port skip taken on one bit");

   t1_load_both_a: assert property (
      dec_t1_low |=> (first_timer_count == $past(ab_word))
                  && (first_timer_low_reload == $past(ab_word)) && exec_done)
      else $error("first timer load wrong");

   t1_high_op_a: assert property (
      dec_t1_high |=> exec_done && !skip_next && in_idle)
      else $error("first high reload not single cycle");

   t1_high_upper_a: assert property (
      dec_t1_high |=> (first_timer_high_reload[NIBBLE_MSB:NIBBLE_LSB] == $past(opnd.breg))
                   && $stable(first_timer_count))
      else $error("first high reload upper nibble or counter wrong");

   t1_high_lower_a: assert property (
      dec_t1_high |=> first_timer_high_reload[3:0] == $past(opnd.acc))
      else $error("first high reload lower nibble wrong");

   copy_low_a: assert property (
      dec_copy_t1 |=> (first_timer_count == $past(first_timer_low_reload))
                   && $stable(first_timer_low_reload))
      else $error("low reload copy wrong");

   t2_load_both_a: assert property (
      dec_t2_low |=> (second_timer_count == $past(ab_word))
                  && (second_timer_low_reload == $past(ab_word)))
      else $error("second timer load wrong");

   t2_high_load_a: assert property (
      dec_t2_high |=> (second_timer_high_reload == $past(ab_word))
                   && $stable(second_timer_count))
      else $error("second high reload wrong");

   same_edge_a: assert property (
      $changed(second_timer_low_reload) |-> $past(dec_t2_low)
                                          && (second_timer_count == second_timer_low_reload))
      else $error("second counter and reload split");

   t1_same_edge_a: assert property (
      $changed(first_timer_low_reload) |-> $past(dec_t1_low)
                                         && (first_timer_count == first_timer_low_reload))
      else $error("first counter and reload split");

   // a stray word that ends the skip wait must not complete, skip or change the first timer counter or low reload
   stray_word_a: assert property (
      !in_idle && req.valid && (req.code != OP_SKIP_PORT_W2)
      |=> !exec_done && !skip_next && $stable(first_timer_count) && $stable(first_timer_low_reload))
      else $error("stray word after skip start acted on");

endmodule

// File: core/transfer_ops_pkg.sv
// Function
// - skip next instruction when port output bit picked by pointer is zero
// - first timer load writes b:a into counter and low reload, one cycle
// - decode first high reload load; one word, carry untouched, never skips
// - first high reload load puts b in upper nibble, counter untouched
// - first high reload load puts accumulator into lower nibble
// - code 2a7 copies first low reload into first timer counter
// - second timer load writes b:a into counter and low reload
// - decode second high reload load, b upper nibble, a lower nibble
package transfer_ops_pkg;

   // ***************************************
   // instruction codes
   // ***************************************
   localparam logic [9:0] OP_SKIP_PORT_W1   = 10'h024;
   localparam logic [9:0] OP_SKIP_PORT_W2   = 10'h02b;
   localparam logic [9:0] OP_LOAD_T1_LOW    = 10'h230;
   localparam logic [9:0] OP_LOAD_T1_HIGH   = 10'h292;
   localparam logic [9:0] OP_COPY_LOW_T1    = 10'h2a7;
   localparam logic [9:0] OP_LOAD_T2_LOW    = 10'h231;
   localparam logic [9:0] OP_LOAD_T2_HIGH   = 10'h294;

   // ***************************************
   // reset values and limits
   // ***************************************
   localparam logic [7:0] TIMER_RESET       = 8'h00;
   localparam logic [3:0] PTR_LIMIT         = 4'h3;
   localparam int         NIBBLE_MSB        = 7;
   localparam int         NIBBLE_LSB        = 4;

   // ***************************************
   // types
   // ***************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SKIP = 2'b10
   } dec_state_t;

   typedef struct packed {
      logic       valid;
      logic [9:0] code;
   } instr_req_t;

   typedef struct packed {
      logic [3:0] acc;
      logic [3:0] breg;
      logic [3:0] ptr_y;
   } operand_t;

   typedef struct packed {
      dec_state_t state;
      logic       skip_next;
      logic       done;
   } ctrl_state_t;

   typedef struct packed {
      logic [7:0] value;
   } byte_state_t;

endpackage

// File: test/timer_reload_transfer_ops_tb.sv
`timescale 1ns/1ps
module timer_reload_transfer_ops_tb;
   import transfer_ops_pkg::*;

   // ***************************************
   // design hookup
   // ***************************************
   logic       mclk = 1'b0;
   logic       rst  = 1'b1;
   instr_req_t req  = '0;
   operand_t   opnd = '0;
   logic [3:0] port_out_bits = 4'h0;
   logic [7:0] first_timer_count, first_timer_low_reload, first_timer_high_reload;
   logic [7:0] second_timer_count, second_timer_low_reload, second_timer_high_reload;
   logic       skip_next, exec_done;
   logic [7:0] m_c1 = 8'h00, m_l1 = 8'h00, m_h1 = 8'h00, m_c2 = 8'h00, m_l2 = 8'h00, m_h2 = 8'h00;
   logic       m_skip = 1'b0, m_done = 1'b0, m_wait = 1'b0;
   logic [31:0] seed = 32'hc4346d05;
   logic [9:0] ops [0:6];
   int         error_cnt = 0, total_checks = 0, cycles = 0;

   always #10 mclk = ~mclk;

   timer_reload_transfer_ops i_timer_reload_transfer_ops (
      .mclk(mclk), .rst(rst), .req(req), .opnd(opnd), .port_out_bits(port_out_bits),
      .first_timer_count(first_timer_count), .first_timer_low_reload(first_timer_low_reload),
      .first_timer_high_reload(first_timer_high_reload), .second_timer_count(second_timer_count),
      .second_timer_low_reload(second_timer_low_reload),
      .second_timer_high_reload(second_timer_high_reload), .skip_next(skip_next), .exec_done(exec_done));

   // ***************************************
   // reference model
   // ***************************************
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         {m_c1, m_l1, m_h1, m_c2, m_l2, m_h2} = '0;
         {m_skip, m_done, m_wait} = 3'b000;
      end else begin
         m_skip = 1'b0;
         m_done = 1'b0;
         if (req.valid === 1'b1) begin
            if (m_wait) begin
               // any word ends the wait; only the second skip word completes it
               m_wait = 1'b0;
               if (req.code == OP_SKIP_PORT_W2) begin
                  m_done = 1'b1;
                  m_skip = (opnd.ptr_y <= PTR_LIMIT) && !port_out_bits[opnd.ptr_y[1:0]];
               end
            end else begin
               case (req.code)
                  OP_SKIP_PORT_W1: m_wait = 1'b1;
                  OP_LOAD_T1_LOW: begin
                     m_c1 = {opnd.breg, opnd.acc};
                     m_l1 = {opnd.breg, opnd.acc};
                  end
                  OP_LOAD_T1_HIGH: m_h1 = {opnd.breg, opnd.acc};
                  OP_COPY_LOW_T1:  m_c1 = m_l1;
                  OP_LOAD_T2_LOW: begin
                     m_c2 = {opnd.breg, opnd.acc};
                     m_l2 = {opnd.breg, opnd.acc};
                  end
                  OP_LOAD_T2_HIGH: m_h2 = {opnd.breg, opnd.acc};
                  default: ;
               endcase
               m_done = (req.code inside {OP_LOAD_T1_LOW, OP_LOAD_T1_HIGH, OP_COPY_LOW_T1,
                                          OP_LOAD_T2_LOW, OP_LOAD_T2_HIGH});
            end
         end
      end
   end

   // ***************************************
   // checks
   // ***************************************
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic s);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %b seen %b", nm, e, s);
      end
   endtask

   task automatic complete_run();
      if (error_cnt == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // compare every cycle, away from the edge so both sides have settled
   always @(negedge mclk) begin
      chk8("first_timer_count", m_c1, first_timer_count);
      chk8("first_timer_low_reload", m_l1, first_timer_low_reload);
      chk8("first_timer_high_reload", m_h1, first_timer_high_reload);
      chk8("second_timer_count", m_c2, second_timer_count);
      chk8("second_timer_low_reload", m_l2, second_timer_low_reload);
      chk8("second_timer_high_reload", m_h2, second_timer_high_reload);
      chk1("skip_next", m_skip, skip_next);
      chk1("exec_done", m_done, exec_done);
      cycles++;
      if (cycles >= 3000) begin
         error_cnt++;
         complete_run();
      end
   end

   // ***************************************
   // stimulus
   // ***************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // pointer kept at zero to three, the range software may use for the skip
   // a pointer of zero or more replaces the random pointer and port bits, so each pin is set once per step
   task automatic drive(input logic v, input logic [9:0] c, input int p = -1, input logic [3:0] bits = 4'h0);
      logic [31:0] r;
      @(posedge mclk);
      #1;
      r = rnd();
      req.valid = v;
      req.code = c;
      opnd.acc = r[3:0];
      opnd.breg = r[7:4];
      if (p >= 0) begin
         opnd.ptr_y = p[3:0];
         port_out_bits = bits;
      end else begin
         opnd.ptr_y = {2'b00, r[9:8]};
         port_out_bits = r[15:12];
      end
   endtask

   task automatic skip_test(input int p, input logic [3:0] bits);
      drive(1'b1, OP_SKIP_PORT_W1);
      drive(1'b1, OP_SKIP_PORT_W2, p, bits);
   endtask

   initial begin
      logic [31:0] r;
      ops = '{OP_SKIP_PORT_W1, OP_SKIP_PORT_W2, OP_LOAD_T1_LOW, OP_LOAD_T1_HIGH,
              OP_COPY_LOW_T1, OP_LOAD_T2_LOW, OP_LOAD_T2_HIGH};
      repeat (3) @(posedge mclk);
      #1 rst = 1'b0;
      for (int i = 2; i < 7; i++) drive(1'b1, ops[i]);
      drive(1'b1, OP_COPY_LOW_T1);
      for (int i = 0; i < 8; i++)
         skip_test(i % 4, (i < 4) ? (4'hf ^ (4'h1 << (i % 4))) : (4'h1 << (i % 4)));
      drive(1'b1, OP_SKIP_PORT_W1);
      drive(1'b1, OP_LOAD_T1_LOW);
      drive(1'b1, OP_SKIP_PORT_W2);
      drive(1'b1, OP_SKIP_PORT_W1);
      drive(1'b0, OP_SKIP_PORT_W2);
      drive(1'b0, 10'h000);
      drive(1'b1, OP_SKIP_PORT_W2);
      drive(1'b1, OP_LOAD_T1_HIGH);
      @(posedge mclk);
      #1 rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (1500) begin
         r = rnd();
         drive(r[31:30] != 2'b00, (r[20:18] == 3'h7) ? r[29:20] : ops[r[20:18]]);
      end
      drive(1'b0, 10'h000);
      @(posedge mclk);
      @(negedge mclk);
      #1 complete_run();
   end
endmodule
